// >>> inc/est_regs.svh
`ifndef EST_REGS_SVH
`define EST_REGS_SVH

// Register byte addresses
`define EST_ADDR_TX_STAT_CTRL   12'h000
`define EST_ADDR_RX_STAT_CTRL   12'h004
`define EST_ADDR_BAUD_CTRL      12'h008
`define EST_ADDR_BAUD_DIV_LOW   12'h00C
`define EST_ADDR_BAUD_DIV_HIGH  12'h010
`define EST_ADDR_TX_BUFFER      12'h014

// transmit_status_control fields
`define EST_TXS_NINTH_BIT       0
`define EST_TXS_SHIFTER_EMPTY   1
`define EST_TXS_HIGH_SPEED      2
`define EST_TXS_CLOCKED_MODE    4
`define EST_TXS_TX_ENABLE       5
`define EST_TXS_NINE_BIT_SEL    6
// receive_status_control fields
`define EST_RXS_PORT_ENABLE     7
// baud_control fields
`define EST_BDC_WIDE_DIV        3
`define EST_BDC_POL_INVERT      4
// Status bits on the flag word (transmit_status_control read bit 7 holds the buffer empty flag)
`define EST_TXS_BUF_EMPTY_FLAG  7

// Reset values
`define EST_RST_TX_STAT_CTRL    8'h02
`define EST_RST_RX_STAT_CTRL    8'h00
`define EST_RST_BAUD_CTRL       8'h00
`define EST_RST_BAUD_DIV        8'h00

// Oversampling ratios
`define EST_OVS_LOW_SPEED       5'd16
`define EST_OVS_HIGH_SPEED      5'd4
// Flag update delay after a buffer write, in clock cycles
`define EST_FLAG_DELAY          2

`endif

// >>> inc/est_pkg.sv
package est_pkg;
   typedef enum logic [1:0] {
      EST_IDLE  = 2'b00,
      EST_START = 2'b01,
      EST_DATA  = 2'b10,
      EST_STOP  = 2'b11
   } est_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } est_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } est_apb_rsp_t;

   typedef struct packed {
      logic out;
      logic oe;
   } est_pin_t;
endpackage : est_pkg

// >>> hw/est_transmitter.sv
`timescale 1ns/1ps
`include "est_regs.svh"
// Overview of operation
// - Line idles mark; start, data, stop
// - Data shifted LSb first, shared format
// - No hardware parity; ninth bit only
// - Active when enable, async, port on
// - Port enable drives transmit pin out
// - Disabled port releases pin to GPIO
// - Transmit enable sets buffer empty flag
// - Buffer write loads idle shifter one cycle later
// - Queued char loads one cycle after stop
// - Frame begins right after shifter load
// - Polarity bit inverts idle and data
// - Flag set unless shifter busy and queued
// - Flag valid second cycle after write
// - Flag read-only, hardware driven
// - Flag independent of interrupt enable
// - Shifter empty status read-only, tracks shifter
// - Shifter empty raises no interrupt
// - Nine bits load together, ninth is MSb
// - Bit time from 8/16-bit divider
module est_transmitter #(
   parameter int DATA_BITS = 9
)(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire est_pkg::est_apb_req_t apb_req,
   output      est_pkg::est_apb_rsp_t apb_rsp,
   // Transmit pin and GPIO fallback
   input  wire logic                  gpio_out,
   input  wire logic                  gpio_oe,
   output      est_pkg::est_pin_t     tx_pin,
   // Status toward the interrupt controller
   output      logic                  tx_buf_empty_flag
);
   import est_pkg::*;

   initial
   begin
      if (DATA_BITS != 9)
         $error("est_transmitter supports nine data bits only");
   end

   // ==========================================================
   // Register bus
   logic [7:0] tx_ctrl_reg;
   logic [7:0] rx_ctrl_reg;
   logic [7:0] baud_ctrl_reg;
   logic [7:0] div_low_reg;
   logic [7:0] div_high_reg;
   logic       wr_en;
   logic       port_on;
   logic       tx_active;
   logic       shifter_empty;

   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign port_on = rx_ctrl_reg[`EST_RXS_PORT_ENABLE];
   assign tx_active = tx_ctrl_reg[`EST_TXS_TX_ENABLE]
                    & ~tx_ctrl_reg[`EST_TXS_CLOCKED_MODE]
                    & port_on;

   // Status bits stored as ones below are masked off; hardware owns them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_ctrl_reg   <= `EST_RST_TX_STAT_CTRL;
         rx_ctrl_reg   <= `EST_RST_RX_STAT_CTRL;
         baud_ctrl_reg <= `EST_RST_BAUD_CTRL;
         div_low_reg   <= `EST_RST_BAUD_DIV;
         div_high_reg  <= `EST_RST_BAUD_DIV;
      end
      else if (wr_en)
      begin
         case (apb_req.paddr)
            `EST_ADDR_TX_STAT_CTRL:
               tx_ctrl_reg <= apb_req.pwdata[7:0] & 8'h7D;
            `EST_ADDR_RX_STAT_CTRL:
               rx_ctrl_reg <= apb_req.pwdata[7:0] & 8'h80;
            `EST_ADDR_BAUD_CTRL:
               baud_ctrl_reg <= apb_req.pwdata[7:0] & 8'h18;
            `EST_ADDR_BAUD_DIV_LOW:
               div_low_reg <= apb_req.pwdata[7:0];
            `EST_ADDR_BAUD_DIV_HIGH:
               div_high_reg <= apb_req.pwdata[7:0];
            default:
               tx_ctrl_reg <= tx_ctrl_reg;
         endcase
      end
   end

   logic       addr_ok;
   logic [7:0] rd_byte;
   always_comb
   begin
      addr_ok = 1'b1;
      rd_byte = 8'h00;
      case (apb_req.paddr)
         `EST_ADDR_TX_STAT_CTRL:
         begin
            rd_byte = tx_ctrl_reg;
            rd_byte[`EST_TXS_SHIFTER_EMPTY] = shifter_empty;
            rd_byte[`EST_TXS_BUF_EMPTY_FLAG] = tx_buf_empty_flag;
         end
         `EST_ADDR_RX_STAT_CTRL:  rd_byte = rx_ctrl_reg;
         `EST_ADDR_BAUD_CTRL:     rd_byte = baud_ctrl_reg;
         `EST_ADDR_BAUD_DIV_LOW:  rd_byte = div_low_reg;
         `EST_ADDR_BAUD_DIV_HIGH: rd_byte = div_high_reg;
         `EST_ADDR_TX_BUFFER:     rd_byte = 8'h00;
         default:                 addr_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
      apb_rsp.prdata  = {24'h000000, rd_byte};
   end

   // ==========================================================
   // Baud tick generator
   logic [15:0] div_reg;
   logic [15:0] div_next;
   logic [3:0]  ovs_reg;
   logic [4:0]  ovs_ratio;
   logic        baud_tick;
   logic        bit_tick;
   logic        in_frame;

   // Reload value and ratio from the speed selects
   always_comb
   begin
      if (baud_ctrl_reg[`EST_BDC_WIDE_DIV])
         div_next = {div_high_reg, div_low_reg};
      else
         div_next = {8'h00, div_low_reg};
      ovs_ratio = tx_ctrl_reg[`EST_TXS_HIGH_SPEED] ? `EST_OVS_HIGH_SPEED
                                                   : `EST_OVS_LOW_SPEED;
   end

   assign baud_tick = (div_reg == 16'h0000);
   assign bit_tick = baud_tick && ({1'b0, ovs_reg} == ovs_ratio - 5'd1);

   // Counters restart with each frame so the start bit is full length
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg <= 16'h0000;
         ovs_reg <= 4'h0;
      end
      else if (!in_frame)
      begin
         div_reg <= div_next;
         ovs_reg <= 4'h0;
      end
      else if (baud_tick)
      begin
         div_reg <= div_next;
         ovs_reg <= bit_tick ? 4'h0 : ovs_reg + 4'h1;
      end
      else
         div_reg <= div_reg - 16'h0001;
   end

   // ==========================================================
   // Buffer and shifter
   logic [8:0]  buf_reg;
   logic        buf_full_reg;
   logic [8:0]  shift_reg;
   logic [3:0]  bit_cnt_reg;
   est_state_t  state_reg;
   logic        buf_write;
   logic        load_shifter;
   logic        frame_done;

   assign buf_write = wr_en && apb_req.paddr == `EST_ADDR_TX_BUFFER
                    && tx_active;
   assign in_frame = (state_reg != EST_IDLE);
   assign shifter_empty = ~in_frame;
   assign frame_done = (state_reg == EST_STOP) && bit_tick;
   // Queued char loads in the cycle after stop ends
   assign load_shifter = tx_active && buf_full_reg && !in_frame;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         buf_reg      <= 9'h000;
         buf_full_reg <= 1'b0;
      end
      else if (!port_on || !tx_active)
         buf_full_reg <= 1'b0;
      else if (buf_write)
      begin
         // Ninth bit sampled now; software sets it first
         buf_reg <= {tx_ctrl_reg[`EST_TXS_NINTH_BIT],
                     apb_req.pwdata[7:0]};
         buf_full_reg <= 1'b1;
      end
      else if (load_shifter)
         buf_full_reg <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg   <= EST_IDLE;
         shift_reg   <= 9'h000;
         bit_cnt_reg <= 4'h0;
      end
      else if (!tx_active)
         state_reg <= EST_IDLE;
      else
      begin
         case (state_reg)
            EST_IDLE:
               if (load_shifter)
               begin
                  shift_reg <= buf_reg;
                  state_reg <= EST_START;
               end
            EST_START:
               if (bit_tick)
               begin
                  bit_cnt_reg <= tx_ctrl_reg[`EST_TXS_NINE_BIT_SEL]
                               ? 4'd8 : 4'd7;
                  state_reg   <= EST_DATA;
               end
            EST_DATA:
               if (bit_tick)
               begin
                  shift_reg <= {1'b0, shift_reg[8:1]};
                  if (bit_cnt_reg == 4'h0)
                     state_reg <= EST_STOP;
                  else
                     bit_cnt_reg <= bit_cnt_reg - 4'h1;
               end
            EST_STOP:
               if (frame_done)
                  state_reg <= EST_IDLE;
            default:
               state_reg <= EST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Buffer empty flag, two-cycle settle after a write
   logic [1:0] write_dly_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         write_dly_reg <= 2'b00;
      else
         write_dly_reg <= {write_dly_reg[0], buf_write};
   end

   // Held stale for a cycle; the write only shows at the second edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_buf_empty_flag <= 1'b0;
      else if (!tx_active)
         tx_buf_empty_flag <= 1'b0;
      else if (!buf_write && !write_dly_reg[0])
         tx_buf_empty_flag <= !buf_full_reg;
   end

   // ==========================================================
   // Transmit pin
   logic line_level;
   always_comb
   begin
      case (state_reg)
         EST_START: line_level = 1'b0;
         EST_DATA:  line_level = shift_reg[0];
         default:   line_level = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_pin <= '{out: 1'b0, oe: 1'b0};
      else if (port_on)
         tx_pin <= '{out: line_level
                           ^ baud_ctrl_reg[`EST_BDC_POL_INVERT],
                     oe: 1'b1};
      else
         tx_pin <= '{out: gpio_out, oe: gpio_oe};
   end

   // ==========================================================
   // Checks
   AST_IDLE_MARK: assert property (@(posedge pclk) disable iff (!presetn)
      (port_on && !in_frame && !baud_ctrl_reg[`EST_BDC_POL_INVERT])
      |=> tx_pin.out || !port_on || in_frame)
      else $error("line not at mark while idle");
   AST_START_SPACE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_reg == EST_START) && !baud_ctrl_reg[`EST_BDC_POL_INVERT]
      && port_on |=> !tx_pin.out)
      else $error("start bit not a space");
   AST_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_active |=> !in_frame)
      else $error("frame running while inactive");
   AST_PIN_OE: assert property (@(posedge pclk) disable iff (!presetn)
      port_on |=> tx_pin.oe)
      else $error("pin not driven with port on");
   AST_LOAD_NOW: assert property (@(posedge pclk) disable iff (!presetn)
      buf_write && !in_frame && !buf_full_reg |=> ##1 in_frame
      || !tx_active)
      else $error("idle shifter not loaded");
   AST_QUEUE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      frame_done && buf_full_reg && tx_active |=> ##1 in_frame)
      else $error("queued char not loaded");
   AST_FLAG_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
      buf_write && tx_buf_empty_flag |=> tx_buf_empty_flag)
      else $error("flag changed too early");
   AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      tx_active && !tx_buf_empty_flag |-> $past(buf_full_reg)
      || !$past(tx_active)
      || $past(buf_write) || $past(write_dly_reg[0]))
      else $error("flag clear without queued char");
   AST_SHIFT_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
      load_shifter |=> !shifter_empty)
      else $error("shifter empty after load");
endmodule : est_transmitter

// >>> sim/est_rx_model.sv
`timescale 1ns/1ps
// ==========================================
// Far-end receiver on the transmit line
module est_rx_model #(
   parameter int BIT_CYC = 8
)(
   // Clock
   input  wire logic       pclk,
   // Line and format
   input  wire logic       line,
   input  wire logic       inv,
   input  wire logic       nine,
   input  wire logic       en,
   // Received character
   output logic            valid,
   output logic [8:0]      data
);
   logic       lvl;
   logic [8:0] d;
   assign lvl = line ^ inv;
   initial valid = 1'b0;
   // Negedge sampling keeps clear of the registered pin
   always
   begin
      @(negedge pclk);
      valid <= 1'b0;
      if (en && lvl === 1'b0)
      begin
         d = '0;
         repeat (BIT_CYC / 2) @(negedge pclk);
         for (int i = 0; i < (nine ? 9 : 8); i++)
         begin
            repeat (BIT_CYC) @(negedge pclk);
            d[i] = lvl;
         end
         repeat (BIT_CYC) @(negedge pclk);
         // Torn frames after an abort are dropped
         if (en && lvl === 1'b1)
         begin
            data  <= d;
            valid <= 1'b1;
         end
      end
   end
endmodule : est_rx_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "est_regs.svh"
module testbench;
   import est_pkg::*;
   // ==========================================
   // Signals
   logic          pclk, presetn, gpio_out, gpio_oe, flag;
   logic          inv, nine, pe, rx_valid, serr;
   logic [8:0]    rx_data;
   logic [31:0]   rdata, seed;
   int            num_errors, total_checks, cyc;
   est_apb_req_t  req;
   est_apb_rsp_t  rsp;
   est_pin_t      pin;
   logic [8:0]    exp_q[$];
   est_transmitter dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .tx_pin(pin), .tx_buf_empty_flag(flag));
   // Pull-up on the line when nobody drives
   est_rx_model #(.BIT_CYC(8)) rx (.pclk(pclk),
      .line(pin.oe ? pin.out : 1'b1), .inv(inv), .nine(nine), .en(pe),
      .valid(rx_valid), .data(rx_data));
   always #12.5 pclk = ~pclk;
   // ==========================================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task stop_test();
      $display("errors=%0d checks=%0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task cmp_val(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_val
   task cmp_chr(input logic [8:0] g, input logic [8:0] e);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_chr
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      rdata = rsp.prdata;
      serr  = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp_val(rdata, e);
   endtask : rchk
   task send(input logic [8:0] c, input bit expect_it);
      if (expect_it)
         exp_q.push_back(c);
      apb(1'b1, `EST_ADDR_TX_BUFFER, {24'h0, c[7:0]});
   endtask : send
   task settle();
      while (exp_q.size() != 0)
         @(posedge pclk);
      repeat (12) @(posedge pclk);
   endtask : settle
   // ==========================================
   // Result watcher and timeout
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         num_errors++;
         stop_test();
      end
      if (rx_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp_chr(rx_data, 9'h1FF);
         else
            cmp_chr(rx_data, exp_q.pop_front());
      end
   end
   // ==========================================
   // Main sequence
   initial
   begin
      pclk = 0; presetn = 0; req = '0; gpio_out = 1; gpio_oe = 0;
      inv = 0; nine = 0; pe = 0; seed = 32'd44706;
      num_errors = 0; total_checks = 0; cyc = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`EST_ADDR_TX_STAT_CTRL, 32'h02);
      rchk(`EST_ADDR_BAUD_CTRL, 32'h00);
      rchk(12'hFFC, 32'h0);
      cmp_val(serr, 1'b1);
      gpio_oe <= 1'b1;
      gpio_out <= 1'b0;
      send(9'h55, 0);
      repeat (3) @(posedge pclk);
      cmp_val({pin.oe, pin.out, flag}, 3'b100);
      // Divider first, port enable, then transmit enable
      apb(1'b1, `EST_ADDR_BAUD_DIV_LOW, 32'h01);
      apb(1'b1, `EST_ADDR_BAUD_DIV_HIGH, 32'h00);
      apb(1'b1, `EST_ADDR_RX_STAT_CTRL, 32'h80);
      // Far end listens only once the pin has left the GPIO level
      @(posedge pclk);
      pe <= 1'b1;
      @(posedge pclk);
      cmp_val({pin.oe, pin.out}, 2'b11);
      apb(1'b1, `EST_ADDR_TX_STAT_CTRL, 32'h24);
      repeat (2) @(posedge pclk);
      cmp_val(flag, 1'b1);
      send({1'b0, 8'(xs())}, 1);
      send({1'b0, 8'(xs())}, 1);
      @(posedge pclk);
      cmp_val(flag, 1'b1);
      repeat (2) @(posedge pclk);
      cmp_val(flag, 1'b0);
      rchk(`EST_ADDR_TX_STAT_CTRL, 32'h24);
      settle();
      rchk(`EST_ADDR_TX_STAT_CTRL, 32'hA6);
      nine = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         // Ninth bit goes in before the low byte
         apb(1'b1, `EST_ADDR_TX_STAT_CTRL, 32'h64 | k);
         send({k[0], 8'(xs())}, 1);
         settle();
      end
      nine = 1'b0;
      apb(1'b1, `EST_ADDR_TX_STAT_CTRL, 32'h24);
      apb(1'b1, `EST_ADDR_BAUD_CTRL, 32'h10);
      // Model polarity flips in the same cycle as the pin
      @(posedge pclk);
      inv <= 1'b1;
      @(posedge pclk);
      cmp_val(pin.out, 1'b0);
      send({1'b0, 8'(xs())}, 1);
      settle();
      // Clocked mode must block the asynchronous path
      apb(1'b1, `EST_ADDR_TX_STAT_CTRL, 32'h34);
      send(9'h0F, 0);
      repeat (120) @(posedge pclk);
      apb(1'b1, `EST_ADDR_TX_STAT_CTRL, 32'h24);
      send(9'h33, 0);
      repeat (20) @(posedge pclk);
      apb(1'b1, `EST_ADDR_RX_STAT_CTRL, 32'h00);
      pe = 1'b0;
      repeat (2) @(posedge pclk);
      cmp_val({pin.oe, pin.out, flag}, 3'b100);
      repeat (120) @(posedge pclk);
      apb(1'b1, `EST_ADDR_RX_STAT_CTRL, 32'h80);
      pe = 1'b1;
      repeat (2) @(posedge pclk);
      rchk(`EST_ADDR_TX_STAT_CTRL, 32'hA6);
      cmp_val(exp_q.size(), 32'h0);
      stop_test();
   end
endmodule : testbench
